/* watchdog_pkg.sv */
// package: register map, field positions and timing constants of the watchdog
package watchdog_pkg;
   // apb byte addresses (documented offsets are not multiples of four: index * 4)
   localparam logic [11:0] IDX_COUNTER  = 12'h023;
   localparam logic [11:0] IDX_KEY      = 12'h025;
   localparam logic [11:0] IDX_CONTROL  = 12'h029;
   localparam logic [11:0] IDX_IRQ_STAT = 12'h030;
   localparam logic [11:0] IDX_IRQ_MASK = 12'h031;
   localparam logic [13:0] ADDR_COUNTER  = {IDX_COUNTER, 2'b00};
   localparam logic [13:0] ADDR_KEY      = {IDX_KEY, 2'b00};
   localparam logic [13:0] ADDR_CONTROL  = {IDX_CONTROL, 2'b00};
   localparam logic [13:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
   localparam logic [13:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
   // control register fields
   localparam int FLAG_BIT    = 7;
   localparam int DIS_BIT     = 6;
   localparam int CHK_HI_BIT  = 5;
   localparam int CHK_MID_BIT = 4;
   localparam int CHK_LO_BIT  = 3;
   localparam int PS_MSB      = 2;
   localparam logic [2:0] CHK_GOOD = 3'h5;
   localparam logic [2:0] PS_RESET = 3'h0;
   // service keys
   localparam logic [7:0] KEY_ARM   = 8'h55;
   localparam logic [7:0] KEY_CLEAR = 8'haa;
   // interrupt status bits
   localparam int IRQ_OVF = 0;
   localparam int IRQ_KEY = 1;
   localparam int IRQ_CHK = 2;
   localparam int IRQ_W   = 3;
   // timing
   localparam real CLK_MHZ        = 125.0;
   localparam real WATCHDOG_CLOCK_HZ       = 39062.5;
   localparam int  WATCHDOG_CLOCK_DIV      = int'(CLK_MHZ * 1.0e6 / WATCHDOG_CLOCK_HZ);
   localparam int  PRESCALE_W     = 6;
   localparam int  CNT_W          = 8;
endpackage

/* watchdog_control_prescale.sv */
// watchdog timer: control register, prescaler, counter, key service and reset
`timescale 1ns/1ns
// Summary of operation
// - soft disable bit 0 keeps running, 1 stops it when permitted.
// - control write with check bit 5 clear resets system; reads as 0.
// - control write with check bit 4 set resets system; reads as 0.
// - control write with check bit 3 clear resets system; reads as 0.
// - prescale 00x divides by 1, then 2,4,8,16,32,64.
// - counter runs 257 selected periods from clear before reset.
// - servicing the counter never clears the prescaler.
// - at 39062.5 Hz timeout spans 6.55 ms to 419.43 ms.
// - pin low keeps the watchdog always active.
// - 55h then AAh clears counter; other key values reset system.
// - reset follows overflow by one selected clock period.
// - soft disable bit writable only while the pin is high.
// - overflow or bad key sets the watchdog reset flag.
module watchdog_control_prescale #(
   parameter int WATCHDOG_CLOCK_DIV = watchdog_pkg::WATCHDOG_CLOCK_DIV
)(
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [15:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        disable_enable_pin_in,
   output logic             sys_reset_out,
   output logic             irq_out
);
   localparam int CW = watchdog_pkg::CNT_W;
   localparam int PW = watchdog_pkg::PRESCALE_W;

   // ==========================================================
   // apb decode
   logic        wr_en;
   logic        rd_en;
   logic        hit_cnt;
   logic        hit_key;
   logic        hit_ctl;
   logic        hit_ist;
   logic        hit_imk;
   logic        mapped;
   assign hit_cnt = paddr_in[13:0] == watchdog_pkg::ADDR_COUNTER;
   assign hit_key = paddr_in[13:0] == watchdog_pkg::ADDR_KEY;
   assign hit_ctl = paddr_in[13:0] == watchdog_pkg::ADDR_CONTROL;
   assign hit_ist = paddr_in[13:0] == watchdog_pkg::ADDR_IRQ_STAT;
   assign hit_imk = paddr_in[13:0] == watchdog_pkg::ADDR_IRQ_MASK;
   // only the low window of the byte address is decoded; anything above it is unmapped
   logic        addr_top_ok;
   assign addr_top_ok = paddr_in[15:14] == 2'h0;
   assign mapped  = (hit_cnt | hit_key | hit_ctl | hit_ist | hit_imk) & addr_top_ok;
   // zero wait states: every access completes in its first access cycle
   assign pready_out  = 1'b1;
   // unmapped accesses answer with an error and change nothing
   assign pslverr_out = psel_in & penable_in & ~mapped;
   assign wr_en = psel_in & penable_in & pwrite_in & mapped;
   assign rd_en = psel_in & ~penable_in & ~pwrite_in;

   // ==========================================================
   // pin synchroniser: three stages, change accepted when 2 and 3 agree
   // the pin is asynchronous; the agreement test hides a single metastable sample
   logic [2:0] pin_sync_r;
   logic       pin_high_r;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         pin_sync_r <= 3'h0;
      else
         pin_sync_r <= {pin_sync_r[1:0], disable_enable_pin_in};
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         pin_high_r <= 1'b0;
      else if (pin_sync_r[1] == pin_sync_r[2])
         pin_high_r <= pin_sync_r[2];
   end

   // ==========================================================
   // watchdog clock enable derived from system clock
   // one-cycle enable pulse: the whole block stays on the single system clock
   logic [15:0] watchdog_clock_cnt_r;
   logic        watchdog_clock_en;
   assign watchdog_clock_en = watchdog_clock_cnt_r == 16'(WATCHDOG_CLOCK_DIV - 1);
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         watchdog_clock_cnt_r <= 16'h0;
      else if (watchdog_clock_en)
         watchdog_clock_cnt_r <= 16'h0;
      else
         watchdog_clock_cnt_r <= watchdog_clock_cnt_r + 16'h1;
   end

   // ==========================================================
   // control register
   logic       soft_dis_r;
   logic [2:0] prescale_r;
   logic       ctl_wr;
   logic       chk_bad;
   logic [2:0] chk_in;
   assign ctl_wr = wr_en & hit_ctl;
   assign chk_in = pwdata_in[watchdog_pkg::CHK_HI_BIT:watchdog_pkg::CHK_LO_BIT];
   assign chk_bad = ctl_wr & (chk_in != watchdog_pkg::CHK_GOOD);
   // the prescale field is taken even from a write whose check bits are wrong
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         prescale_r <= watchdog_pkg::PS_RESET;
      else if (ctl_wr)
         prescale_r <= pwdata_in[watchdog_pkg::PS_MSB:0];
   end
   // writes to the disable bit are dropped while the pin is low
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         soft_dis_r <= 1'b0;
      else if (ctl_wr & pin_high_r)
         soft_dis_r <= pwdata_in[watchdog_pkg::DIS_BIT];
   end

   // software may stop the timer only while the synchronised pin is high
   logic sw_stop;
   logic running;
   assign sw_stop = soft_dis_r & pin_high_r;
   assign running = ~sw_stop;

   // ==========================================================
   // free-running prescaler, never cleared by service
   logic [PW-1:0] pre_r;
   logic [PW-1:0] pre_nxt;
   logic          tick;
   assign pre_nxt = pre_r + PW'(1);
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         pre_r <= '0;
      else if (watchdog_clock_en)
         pre_r <= pre_nxt;
   end
   // tap k fires when the low k+1 bits of the prescaler are all ones
   logic [PW-1:0] tap_hit;
   for (genvar k = 0; k < PW; k++)
   begin : g_tap
      assign tap_hit[k] = &pre_r[k:0];
   end
   // codes 0 and 1 both take the undivided watchdog clock
   always_comb
   begin
      case (prescale_r)
         3'h0, 3'h1: tick = watchdog_clock_en;
         3'h2: tick = watchdog_clock_en & tap_hit[0];
         3'h3: tick = watchdog_clock_en & tap_hit[1];
         3'h4: tick = watchdog_clock_en & tap_hit[2];
         3'h5: tick = watchdog_clock_en & tap_hit[3];
         3'h6: tick = watchdog_clock_en & tap_hit[4];
         3'h7: tick = watchdog_clock_en & tap_hit[5];
         default: tick = watchdog_clock_en;
      endcase
   end

   // ==========================================================
   // key service
   logic       key_wr;
   logic       armed_r;
   logic       service;
   logic       key_bad;
   logic [7:0] key_val;
   assign key_val = pwdata_in[7:0];
   assign key_wr  = wr_en & hit_key;
   assign key_bad = key_wr & (key_val != watchdog_pkg::KEY_ARM) & (key_val != watchdog_pkg::KEY_CLEAR);
   assign service = key_wr & armed_r & (key_val == watchdog_pkg::KEY_CLEAR);
   // every key write re-arms or disarms, so only 55h directly before aah clears
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         armed_r <= 1'b0;
      else if (key_wr)
         armed_r <= key_val == watchdog_pkg::KEY_ARM;
   end

   // ==========================================================
   // counter, overflow and delayed reset
   logic [CW-1:0] cnt_r;
   logic          ovf_r;
   logic          ovf_rst;
   // service clears the counter only; the prescaler phase carries on
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         cnt_r <= '0;
      else if (service)
         cnt_r <= '0;
      else if (running & tick)
         cnt_r <= cnt_r + CW'(1);
   end
   // armed by the 256th tick and spent by the 257th: one reset per overflow
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         ovf_r <= 1'b0;
      else if (service)
         ovf_r <= 1'b0;
      else if (running & tick)
         ovf_r <= &cnt_r;
   end
   // 256 ticks overflow, 257th asserts reset
   assign ovf_rst = ovf_r & running & tick;

   // one registered pulse for any cause, shared when causes coincide; internal state is left for software to inspect
   logic fire;
   assign fire = ovf_rst | key_bad | chk_bad;
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         sys_reset_out <= 1'b0;
      else
         sys_reset_out <= fire;
   end

   // ==========================================================
   // reset-source flag, write one to clear; set wins
   logic flag_r;
   logic flag_clr;
   logic flag_set;
   assign flag_set = ovf_rst | key_bad;
   assign flag_clr = ctl_wr & pwdata_in[watchdog_pkg::FLAG_BIT];
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         flag_r <= 1'b0;
      else if (flag_set)
         flag_r <= 1'b1;
      else if (flag_clr)
         flag_r <= 1'b0;
   end

   // ==========================================================
   // interrupt status and mask
   logic [watchdog_pkg::IRQ_W-1:0] ist_r;
   logic [watchdog_pkg::IRQ_W-1:0] imk_r;
   logic [watchdog_pkg::IRQ_W-1:0] ev;
   logic                           ist_wr;
   logic                           imk_wr;
   assign ist_wr = wr_en & hit_ist;
   assign imk_wr = wr_en & hit_imk;
   always_comb
   begin
      ev = '0;
      ev[watchdog_pkg::IRQ_OVF] = ovf_rst;
      ev[watchdog_pkg::IRQ_KEY] = key_bad;
      ev[watchdog_pkg::IRQ_CHK] = chk_bad;
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         ist_r <= '0;
      // an event in the clearing cycle keeps its bit set
      else if (ist_wr)
         ist_r <= (ist_r & ~pwdata_in[watchdog_pkg::IRQ_W-1:0]) | ev;
      else
         ist_r <= ist_r | ev;
   end
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         imk_r <= '0;
      else if (imk_wr)
         imk_r <= pwdata_in[watchdog_pkg::IRQ_W-1:0];
   end
   assign irq_out = |(ist_r & imk_r);

   // ==========================================================
   // read data, registered in setup phase
   // the key address reads back the control view
   logic [7:0] ctl_view;
   assign ctl_view = {flag_r, soft_dis_r, 3'h0, prescale_r};
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         prdata_out <= 32'h0;
      else if (rd_en)
      begin
         if (hit_cnt)
            prdata_out <= {24'h0, cnt_r};
         else if (hit_key | hit_ctl)
            prdata_out <= {24'h0, ctl_view};
         else if (hit_ist)
            prdata_out <= {29'h0, ist_r};
         else if (hit_imk)
            prdata_out <= {29'h0, imk_r};
         else
            prdata_out <= 32'h0;
      end
   end
endmodule

/* watchdog_chk.sv */
// checker: port-level properties of the watchdog control block
`timescale 1ns/1ns
module watchdog_chk (
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [15:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        disable_enable_pin_in,
   input wire logic        sys_reset_out,
   input wire logic        irq_out
);
   localparam logic [15:0] A_CTL = {2'b00, watchdog_pkg::ADDR_CONTROL};
   localparam logic [15:0] A_KEY = {2'b00, watchdog_pkg::ADDR_KEY};
   wire acc    = psel_in && penable_in;
   wire ctl_wr = acc && pwrite_in && paddr_in == A_CTL;
   wire key_wr = acc && pwrite_in && paddr_in == A_KEY;
   wire ctl_rd = acc && !pwrite_in && (paddr_in == A_CTL || paddr_in == A_KEY);
   wire key_bad = key_wr && pwdata_in[7:0] != watchdog_pkg::KEY_ARM && pwdata_in[7:0] != watchdog_pkg::KEY_CLEAR;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   a_chk_high_reset: assert property (ctl_wr && !pwdata_in[5] |=> sys_reset_out)
      else $error("check bit 5 written low without reset");
   a_chk_mid_reset: assert property (ctl_wr && pwdata_in[4] |=> sys_reset_out)
      else $error("check bit 4 written high without reset");
   a_chk_low_reset: assert property (ctl_wr && !pwdata_in[3] |=> sys_reset_out)
      else $error("check bit 3 written low without reset");
   a_check_read_zero: assert property (ctl_rd |-> prdata_out[5:3] == 3'h0)
      else $error("check bits read nonzero");
   a_bad_key_reset: assert property (key_bad |=> sys_reset_out)
      else $error("bad key without reset");
   a_ready_high: assert property (pready_out)
      else $error("ready low");
   a_slverr_phase: assert property (pslverr_out |-> acc)
      else $error("error outside access phase");
   a_mapped_no_err: assert property (acc && (paddr_in == A_CTL || paddr_in == A_KEY) |-> !pslverr_out)
      else $error("error on mapped register");
   c_bad_check: cover property (ctl_wr && pwdata_in[5:3] != 3'h5 ##1 sys_reset_out);
   c_bad_key: cover property (key_wr && pwdata_in[7:0] == 8'h23);
   c_irq: cover property ($rose(irq_out));
endmodule
bind watchdog_control_prescale watchdog_chk i_watchdog_chk (.clk_in(clk_in), .rstn_in(rstn_in),
   .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .disable_enable_pin_in(disable_enable_pin_in), .sys_reset_out(sys_reset_out), .irq_out(irq_out));

/* watchdog_control_prescale_tb.sv */
// testbench: check bits, service keys, soft disable and timeout of the watchdog
`timescale 1ns/1ns
module watchdog_control_prescale_tb;
   localparam int WDIV = 4;
   localparam logic [15:0] A_CTL = {2'b00, watchdog_pkg::ADDR_CONTROL};
   localparam logic [15:0] A_KEY = {2'b00, watchdog_pkg::ADDR_KEY};
   localparam logic [15:0] A_CNT = {2'b00, watchdog_pkg::ADDR_COUNTER};
   localparam logic [15:0] A_STA = {2'b00, watchdog_pkg::ADDR_IRQ_STAT};
   localparam logic [15:0] A_MSK = {2'b00, watchdog_pkg::ADDR_IRQ_MASK};
   logic clk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, er;
   logic disable_enable_pin_in = 0;
   logic [15:0] paddr_in = '0;
   logic [31:0] pwdata_in = '0, rd;
   wire [31:0] prdata_out;
   wire pready_out, pslverr_out, sys_reset_out, irq_out;
   int mismatches = 0, checked = 0, rst_cnt = 0;
   watchdog_control_prescale #(.WATCHDOG_CLOCK_DIV(WDIV)) i_watchdog_control_prescale (.clk_in(clk_in),
      .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .disable_enable_pin_in(disable_enable_pin_in),
      .sys_reset_out(sys_reset_out), .irq_out(irq_out));
   initial
   begin
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) if (sys_reset_out === 1'b1) rst_cnt <= rst_cnt + 1;
   // ==========================================
   // shared tasks
   task tally_and_finish;
      $display("mismatches=%0d checked=%0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      psel_in <= 1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
      @(posedge clk_in) penable_in <= 1;
      n = 0;
      do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 50);
      rd = prdata_out; er = pslverr_out;
      psel_in <= 0; penable_in <= 0;
      if (n >= 50)
      begin
         mismatches++;
         tally_and_finish();
      end
      @(posedge clk_in);
   endtask
   task automatic do_reset;
      rstn_in <= 0;
      repeat (6) @(posedge clk_in);
      rstn_in <= 1;
      @(posedge clk_in);
   endtask
   // ==========================================
   // scenarios
   task automatic t_check;
      int c0;
      do_reset();
      apb(0, A_CTL, 0); chk(rd, 0);
      for (int k = 0; k < 8; k++)
      begin
         c0 = rst_cnt;
         apb(1, A_CTL, {24'h0, 2'b00, 3'(k), 3'h3});
         repeat (2) @(posedge clk_in);
         chk(32'(rst_cnt - c0), {31'h0, 3'(k) != 3'h5});
         apb(0, A_CTL, 0); chk(rd & 32'h3f, 32'h3);
      end
   endtask
   task automatic t_keys;
      int c0;
      do_reset();
      apb(1, A_MSK, 32'h2);
      c0 = rst_cnt;
      apb(1, A_KEY, 32'haa); apb(1, A_KEY, 32'h55); apb(1, A_KEY, 32'h55); apb(1, A_KEY, 32'haa);
      apb(0, A_CNT, 0); chk(32'(rd < 32'h2), 1);
      chk(32'(rst_cnt - c0), 0);
      apb(1, A_KEY, 32'h23);
      repeat (2) @(posedge clk_in);
      chk(32'(rst_cnt - c0), 1);
      chk({31'h0, irq_out}, 1);
      apb(0, A_STA, 0); chk(rd, 32'h2);
      apb(0, A_KEY, 0); chk(rd & 32'hb8, 32'h80);
      apb(1, A_STA, 32'h2); chk({31'h0, irq_out}, 0);
      apb(1, A_MSK, 0); apb(1, A_KEY, 32'h11);
      apb(0, A_STA, 0); chk(rd, 32'h2);
      chk({31'h0, irq_out}, 0);
      apb(1, A_CTL, 32'ha8); apb(0, A_CTL, 0); chk(rd, 0);
      apb(0, 16'h0, 0); chk(rd, 0);
      chk({31'h0, er}, 1);
   endtask
   task automatic t_disable;
      logic [31:0] c0;
      do_reset();
      apb(1, A_CTL, 32'h68); apb(0, A_CTL, 0); chk(rd & 32'h40, 0);
      disable_enable_pin_in <= 1;
      repeat (4) @(posedge clk_in);
      apb(1, A_CTL, 32'h68); apb(0, A_CTL, 0); chk(rd & 32'h40, 32'h40);
      apb(0, A_CNT, 0); c0 = rd;
      repeat (40) @(posedge clk_in);
      apb(0, A_CNT, 0); chk(rd, c0);
      disable_enable_pin_in <= 0;
      repeat (6) @(posedge clk_in);
      apb(0, A_CNT, 0); c0 = rd;
      repeat (40) @(posedge clk_in);
      apb(0, A_CNT, 0); chk(32'(rd != c0), 1);
   endtask
   task automatic t_timeout(input logic [2:0] ps);
      int p, n, c0;
      p = WDIV * ((ps < 3'h2) ? 1 : (1 << (ps - 1)));
      do_reset();
      apb(1, A_CTL, {24'h0, 2'b00, 3'h5, ps});
      apb(1, A_KEY, 32'h55); apb(1, A_KEY, 32'haa);
      c0 = rst_cnt;
      n = 0;
      while (rst_cnt == c0 && n < 260 * p)
      begin
         @(posedge clk_in);
         n++;
      end
      chk(32'(n >= 256 * p && n <= 258 * p), 1);
   endtask
   task automatic t_rate(input logic [2:0] ps);
      int p, c0;
      p = WDIV * (1 << (ps - 1));
      do_reset();
      apb(1, A_CTL, {24'h0, 2'b00, 3'h5, ps});
      apb(1, A_KEY, 32'h55); apb(1, A_KEY, 32'haa);
      apb(0, A_CNT, 0); c0 = rd;
      repeat (8 * p) @(posedge clk_in);
      apb(0, A_CNT, 0); chk(32'(rd - c0 >= 8 && rd - c0 <= 9), 1);
   endtask
   initial
   begin
      #600000;
      mismatches++;
      tally_and_finish();
   end
   initial
   begin
      t_check();
      t_keys();
      t_disable();
      for (int s = 0; s < 5; s++) t_timeout(3'(s));
      for (int s = 5; s < 8; s++) t_rate(3'(s));
      tally_and_finish();
   end
endmodule
